/* src/lvdc_top.sv */
// supply monitor control: register file, settle timer, flag and wake
// assumes: APB master on pclk, analog comparator/reference outside
//
// Functional notes
// R1: stable bit reads 1 only after settling
// R2: software keeps interrupt off until stable
// R3: enable bit powers detector up or down
// R4: code 1111 routes external pin to comparator
// R5: codes 0010..1110 pick rising taps; others reserved
// R6: reset loads level 0101, enable 0, stable 0
// R7: each enable starts a stabilisation interval
// R8: software setup order ends enabling interrupt
// R9: software clears flag after stabilisation
// R10: flag cannot rise before reference stable
// R11: start-up interval fixed in time, skipped if shared
// R12: detector runs in sleep; crossing wakes device
// R13: wake vectors only with interrupts globally enabled
// R14: any reset switches the detector off
// R15: software enables detector only briefly
// R16: flag sets when tap falls below reference
// R17: irq is flag and enable; flag is sticky
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "lvdc_params.svh"
module lvdc_top #(
	parameter int REF_START_NS = `LVDC_REF_START_NS,
	parameter int CLK_NS       = `LVDC_CLK_NS
) (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic      [31:0]           prdata,
	output logic                       pslverr,
	// analog front end
	input  wire lvdc_pkg::lvdc_analog_in_type  ana_in,
	output lvdc_pkg::lvdc_analog_ctrl_type     ana_ctrl,
	// core side
	input  wire logic                  sleep_req,
	output logic                       irq_req,
	output logic                       wake_req,
	output logic                       wake_vector
);

	// ----------------------------------------
	// timing
	// ----------------------------------------
	// least time, so round up; never below one cycle
	localparam int SETTLE_RAW = (REF_START_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
	localparam int CW         = $clog2(SETTLE_CYC + 1);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [3:0]             trip_q;      // trip_level_select
	logic                   en_q;        // detect_power_enable
	logic                   flag_q;      // undervoltage_flag
	logic                   ie_q;        // undervoltage_irq_enable
	logic                   gie_q;       // global_irq_enable
	lvdc_pkg::lvdc_state_type state_q;   // sequencer
	lvdc_pkg::lvdc_state_type state_d;
	logic [CW-1:0]          cnt_q;       // settle countdown
	logic [CW-1:0]          cnt_d;
	logic                   pready_q;
	logic [31:0]            prdata_q;
	logic                   pslverr_q;
	lvdc_pkg::lvdc_analog_ctrl_type ana_q;
	lvdc_pkg::lvdc_analog_ctrl_type ana_d;
	logic                   irq_q;
	logic                   wake_q;
	logic                   vector_q;

	// ----------------------------------------
	// synchronised analog levels
	// ----------------------------------------
	logic [1:0] ana_s;       // {comp_below, ref_shared}, two flops deep
	logic       comp_s;      // tap below reference
	logic       shared_s;    // reference already alive

	lvdc_sync #(
		.WIDTH (2)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({ana_in.comp_below, ana_in.ref_shared}),
		.sync_out (ana_s)
	);

	assign comp_s   = ana_s[1];
	assign shared_s = ana_s[0];

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire setup_ph  = psel & ~penable;                  // first cycle
	wire access_ok = psel & penable & pready_q;        // completing edge
	wire wr_go     = access_ok & pwrite & pstrb[0];    // low lane carries all
	wire hit_ctrl  = (paddr == `LVDC_ADDR_CTRL);
	wire hit_irq   = (paddr == `LVDC_ADDR_IRQ);
	wire hit_stat  = (paddr == `LVDC_ADDR_STAT);
	wire hit_any   = hit_ctrl | hit_irq | hit_stat;
	wire wr_ctrl   = wr_go & hit_ctrl;
	wire wr_irq    = wr_go & hit_irq;

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	wire stable_now = (state_q == lvdc_pkg::LVDC_STABLE);
	// upper bits tie to zero, the stable bit is never written [R1] [R6]
	wire [31:0] rd_ctrl = {26'h0000000, stable_now, en_q, trip_q};
	wire [31:0] rd_irq  = {29'h00000000, gie_q, ie_q, flag_q};
	wire [31:0] rd_stat = {28'h0000000, sleep_req, comp_s, state_q};
	wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
	                      hit_irq  ? rd_irq  :
	                      hit_stat ? rd_stat : 32'h00000000;

	// ----------------------------------------
	// apb answer: no wait state, all registered
	// ----------------------------------------
	// loading read data in setup keeps prdata a flop output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup_ph;
			prdata_q  <= setup_ph ? rd_data : 32'h00000000;
			pslverr_q <= setup_ph & ~hit_any;   // unmapped address
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// reset leaves the detector off at level 0101 [R6] [R14]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_q <= `LVDC_TRIP_RESET;
			en_q   <= 1'b0;
		end else if (wr_ctrl) begin
			trip_q <= pwdata[`LVDC_TRIP_MSB:`LVDC_TRIP_LSB];
			en_q   <= pwdata[`LVDC_EN_BIT];   // [R3]
		end
	end

	// ----------------------------------------
	// interrupt enables
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ie_q  <= 1'b0;
			gie_q <= 1'b0;
		end else if (wr_irq) begin
			ie_q  <= pwdata[`LVDC_IE_BIT];
			gie_q <= pwdata[`LVDC_GIE_BIT];
		end
	end

	// ----------------------------------------
	// settle sequencer
	// ----------------------------------------
	// interval counted in cycles of a fixed time, not of code speed;
	// a reference already kept alive for brown-out needs no wait [R11]
	wire [CW-1:0] settle_load = CW'(SETTLE_CYC - 1);

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			lvdc_pkg::LVDC_OFF: begin
				// every enable without a shared reference restarts the interval [R7]
				if (en_q && shared_s) begin
					state_d = lvdc_pkg::LVDC_STABLE;   // [R11]
				end else if (en_q) begin
					state_d = lvdc_pkg::LVDC_SETTLE;
					cnt_d   = settle_load;
				end
			end
			lvdc_pkg::LVDC_SETTLE: begin
				if (!en_q) begin
					state_d = lvdc_pkg::LVDC_OFF;      // [R3]
				end else if (cnt_q == '0) begin
					state_d = lvdc_pkg::LVDC_STABLE;   // [R7]
				end else begin
					cnt_d = cnt_q - CW'(1);
				end
			end
			lvdc_pkg::LVDC_STABLE: begin
				if (!en_q) begin
					state_d = lvdc_pkg::LVDC_OFF;      // [R3]
				end
			end
			default: begin
				state_d = lvdc_pkg::LVDC_OFF;          // illegal code 10
			end
		endcase
	end

	// sequencer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= lvdc_pkg::LVDC_OFF;   // [R14]
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// ----------------------------------------
	// undervoltage flag
	// ----------------------------------------
	// raised only by a stable comparator, so no false set [R10] [R16]
	wire flag_set  = stable_now & comp_s;
	// write one to clear; software does this after settling [R9]
	wire flag_clr  = wr_irq & pwdata[`LVDC_FLAG_BIT];
	wire flag_rise = flag_set & ~flag_q;

	// set beats clear in the same cycle, so no event is lost [R17]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_set | (flag_q & ~flag_clr);
		end
	end

	// ----------------------------------------
	// analog controls
	// ----------------------------------------
	// reserved codes 0000/0001 pass through untouched; software avoids them
	always_comb begin
		ana_d.det_power = en_q;                            // [R3]
		ana_d.ref_power = en_q;
		ana_d.ext_sel   = (trip_q == `LVDC_TRIP_EXT);      // [R4]
		ana_d.tap       = trip_q;                          // [R5]
	end

	// ----------------------------------------
	// core-facing outputs
	// ----------------------------------------
	// wake pulses on a new crossing in sleep; vectoring needs both
	// enables, else execution continues in line [R12] [R13]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// tap shows the reset level, so it matches the code out of reset and follows it one edge later
			ana_q.det_power <= 1'b0;
			ana_q.ref_power <= 1'b0;
			ana_q.ext_sel   <= 1'b0;
			ana_q.tap       <= `LVDC_TRIP_RESET;   // [R6]
			irq_q    <= 1'b0;
			wake_q   <= 1'b0;
			vector_q <= 1'b0;
		end else begin
			ana_q    <= ana_d;
			irq_q    <= flag_q & ie_q;                     // [R17]
			wake_q   <= sleep_req & flag_rise;             // [R12]
			vector_q <= sleep_req & flag_rise & ie_q & gie_q; // [R13]
		end
	end

	// ----------------------------------------
	// port drive
	// ----------------------------------------
	assign pready      = pready_q;
	assign prdata      = prdata_q;
	assign pslverr     = pslverr_q;
	assign ana_ctrl    = ana_q;
	assign irq_req     = irq_q;
	assign wake_req    = wake_q;
	assign wake_vector = vector_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// no new flag while the reference is not stable
	a_flag_blocked: assert property ( // [R10]
		(!flag_q && !stable_now) |=> !flag_q)
		else $error("flag rose before reference stable");

	// stable comparator low sets the flag next edge
	a_flag_set: assert property ( // [R16]
		(stable_now && comp_s) |=> flag_q)
		else $error("flag not set on crossing");

	// flag holds until cleared
	a_flag_sticky: assert property ( // [R17]
		(flag_q && !flag_clr) |=> flag_q)
		else $error("flag dropped without clear");

	// interrupt follows flag and enable one edge later
	a_irq_gate: assert property ( // [R17]
		(flag_q && ie_q) |=> irq_q)
		else $error("irq missing with flag and enable");

	// no interrupt without both flag and enable
	a_irq_quiet: assert property ( // [R17]
		!(flag_q && ie_q) |=> !irq_q)
		else $error("irq without flag and enable");

	// settle counter stops the stable state early
	a_settle_wait: assert property ( // [R7]
		(state_q == lvdc_pkg::LVDC_SETTLE && cnt_q != '0) |=> !stable_now)
		else $error("stable before interval elapsed");

	// interval end reaches stable
	a_settle_done: assert property ( // [R11]
		(state_q == lvdc_pkg::LVDC_SETTLE && cnt_q == '0 && en_q)
		|=> stable_now)
		else $error("stable not reached at interval end");

	// stable bit read back matches the sequencer
	a_stable_read: assert property ( // [R1]
		(setup_ph && hit_ctrl) |=> prdata_q[5] == $past(stable_now)
		##0 prdata_q[31:6] == 26'h0000000)
		else $error("stable bit or upper bits wrong");

	// power follows enable, off state when cleared
	a_power_follow: assert property ( // [R3]
		!en_q |=> !ana_q.det_power && state_q == lvdc_pkg::LVDC_OFF)
		else $error("detector not powered down");

	// code 1111 selects the external pin
	a_ext_route: assert property ( // [R4]
		(trip_q == `LVDC_TRIP_EXT) |=> ana_q.ext_sel && ana_q.tap == 4'hF)
		else $error("external input not routed");

	// tap follows the code
	a_tap_code: assert property ( // [R5]
		1'b1 |=> ana_q.tap == $past(trip_q))
		else $error("tap code mismatch");

	// wake and vector on a crossing in sleep
	a_wake_vec: assert property ( // [R12]
		(sleep_req && flag_rise) |=> wake_q && vector_q == $past(ie_q && gie_q))
		else $error("wake or vector wrong");

	// ----------------------------------------
	// covers
	// ----------------------------------------
	c_settle: cover property (state_q == lvdc_pkg::LVDC_SETTLE ##1 stable_now);
	c_flag:   cover property ($rose(flag_q));
	c_vector: cover property (vector_q);
	c_ext:    cover property (ana_q.ext_sel && flag_q);

endmodule

/* inc/lvdc_params.svh */
// constants of the supply monitor control block
// assumes: included by the package user files, no process inside
`ifndef LVDC_PARAMS_SVH
`define LVDC_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LVDC_ADDR_CTRL     12'h000
`define LVDC_ADDR_IRQ      12'h004
`define LVDC_ADDR_STAT     12'h008

// ----------------------------------------
// control register fields
// ----------------------------------------
`define LVDC_TRIP_LSB      0
`define LVDC_TRIP_MSB      3
`define LVDC_EN_BIT        4
`define LVDC_RSTABLE_BIT   5

// ----------------------------------------
// interrupt register fields
// ----------------------------------------
`define LVDC_FLAG_BIT      0
`define LVDC_IE_BIT        1
`define LVDC_GIE_BIT       2

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define LVDC_TRIP_RESET    4'h5
`define LVDC_TRIP_EXT      4'hF
`define LVDC_TRIP_MIN      4'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define LVDC_REF_START_NS  20000
`define LVDC_CLK_NS        20

`endif

/* inc/lvdc_pkg.sv */
// types of the supply monitor control block
// assumes: constants come from lvdc_params.svh
package lvdc_pkg;

	// detector sequencing, gray along off -> settle -> stable
	typedef enum logic [1:0] {
		LVDC_OFF    = 2'b00,
		LVDC_SETTLE = 2'b01,
		LVDC_STABLE = 2'b11
	} lvdc_state_type;

	// levels coming back from the analog front end
	typedef struct packed {
		logic comp_below;   // selected tap below reference
		logic ref_shared;   // reference already running for brown-out
	} lvdc_analog_in_type;

	// controls going to the analog front end
	typedef struct packed {
		logic       det_power;  // comparator and divider powered
		logic       ref_power;  // reference powered
		logic       ext_sel;    // comparator fed from external pin
		logic [3:0] tap;        // divider tap code
	} lvdc_analog_ctrl_type;

endpackage

/* src/lvdc_sync.sv */
// two-flop synchroniser for asynchronous levels
// assumes: inputs are quasi-static levels from the analog side
`timescale 1ns/1ns
module lvdc_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// ----------------------------------------
	// per-bit flop pairs
	// ----------------------------------------
	genvar i;
	// a net gathers the per-bit outputs, one driver per bit
	wire [WIDTH-1:0] safe_w;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;   // read only by the second flop
			logic safe_q;   // safe for logic
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_q <= 1'b0;
					safe_q <= 1'b0;
				end else begin
					meta_q <= async_in[i];
					safe_q <= meta_q;
				end
			end
			assign safe_w[i] = safe_q;
		end
	endgenerate

	// single continuous driver of the output variable
	assign sync_out = safe_w;

endmodule

/* bench/tb_low_voltage_detect_control.sv */
// self-checking bench of the supply monitor control block
// assumes: lvdc_top alone, APB driven here, analog and core levels driven here
`timescale 1ns/1ns
`include "lvdc_params.svh"
module tb_low_voltage_detect_control;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	// one row of the trip code table
	typedef struct packed {
		logic [31:0] wd;  // written to control
		logic [31:0] rd;  // read back
		logic        ext; // external input routed
	} lvdc_row_type;
	logic                           pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]                    paddr;
	logic [31:0]                    pwdata, prdata, rd;
	logic [3:0]                     pstrb;
	lvdc_pkg::lvdc_analog_in_type   ana_in;
	lvdc_pkg::lvdc_analog_ctrl_type ana_ctrl;
	logic                           sleep_req, irq_req, wake_req, wake_vector, er, wv, wk;
	int                             err_count, n_checks, i, n;
	lvdc_row_type                   rows [5];
	// settle shortened to 10 cycles so the run stays short
	lvdc_top #(.REF_START_NS(200), .CLK_NS(20)) u_lvdc_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .ana_in(ana_in), .ana_ctrl(ana_ctrl), .sleep_req(sleep_req),
		.irq_req(irq_req), .wake_req(wake_req), .wake_vector(wake_vector));
	// ----------------------------------------
	// clock and tasks
	// ----------------------------------------
	// 50 MHz clock
	always #10 pclk = ~pclk;
	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one APB transfer; waits for pready and checks that it came in the first access cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1);
		check("pready wait", k, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask
	// supply dips while asleep; records the wake pulses
	task automatic nap();
		int k;
		sleep_req <= 1'b1;
		ana_in.comp_below <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (wake_req !== 1'b1 && k < 20);
		wk = wake_req;
		wv = wake_vector;
		@(posedge pclk);
		check("wake width", wake_req, 32'h0);
		sleep_req <= 1'b0;
		ana_in.comp_below <= 1'b0;
	endtask
	task automatic tend(input string t);
		$display("test %s done", t);
	endtask
	// single exit of the run
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	// whole run is under two hundred cycles; 4000 leaves ample margin
	initial begin
		#(20 * 4000);
		err_count++;
		$display("watchdog expired");
		test_done();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF; ana_in = '0; sleep_req = 1'b0;
		err_count = 0; n_checks = 0;
		// upper bits and the read-only stable bit are dropped on write
		rows[0] = '{32'h02, 32'h02, 1'b0};
		rows[1] = '{32'h07, 32'h07, 1'b0};
		rows[2] = '{32'h0E, 32'h0E, 1'b0};
		rows[3] = '{32'hEF, 32'h0F, 1'b1};
		rows[4] = '{32'h01, 32'h01, 1'b0};
		cyc(5);
		presetn <= 1'b1;
		cyc(2);
		check("tap reset", ana_ctrl.tap, 32'h5);
		check("power reset", ana_ctrl.det_power, 32'h0);
		apb(1'b0, `LVDC_ADDR_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h05);
		check("ctrl err", er, 32'h0);
		apb(1'b0, `LVDC_ADDR_IRQ, 32'h0);
		check("irq reset", rd, 32'h0);
		tend("reset");
		// trip code table
		for (i = 0; i < 5; i++) begin
			apb(1'b1, `LVDC_ADDR_CTRL, rows[i].wd);
			apb(1'b0, `LVDC_ADDR_CTRL, 32'h0);
			check("ctrl readback", rd, rows[i].rd);
			check("tap code", ana_ctrl.tap, {28'h0, rows[i].rd[3:0]});
			check("ext select", ana_ctrl.ext_sel, rows[i].ext);
		end
		tend("codes");
		// refused accesses
		apb(1'b0, 12'h00C, 32'h0);
		check("unmapped data", rd, 32'h0);
		check("unmapped err", er, 32'h1);
		pstrb <= 4'h0;
		apb(1'b1, `LVDC_ADDR_CTRL, 32'h0E);
		pstrb <= 4'hF;
		apb(1'b0, `LVDC_ADDR_CTRL, 32'h0);
		check("strobe off", rd, 32'h01);
		tend("refused");
		// enable with the supply already low during settling
		ana_in.comp_below <= 1'b1;
		apb(1'b1, `LVDC_ADDR_CTRL, 32'h15);
		apb(1'b0, `LVDC_ADDR_CTRL, 32'h0);
		check("stable early", rd[5], 32'h0);
		check("det power on", ana_ctrl.det_power, 32'h1);
		check("ref power on", ana_ctrl.ref_power, 32'h1);
		apb(1'b0, `LVDC_ADDR_IRQ, 32'h0);
		check("flag in settle", rd[0], 32'h0);
		n = 0;
		do begin
			apb(1'b0, `LVDC_ADDR_CTRL, 32'h0);
			n++;
		end while (rd[5] !== 1'b1 && n < 20);
		check("stable late", rd, 32'h35);
		cyc(4);
		apb(1'b0, `LVDC_ADDR_IRQ, 32'h0);
		check("flag set", rd[0], 32'h1);
		check("irq masked", irq_req, 32'h0);
		ana_in.comp_below <= 1'b0;
		cyc(4);
		apb(1'b1, `LVDC_ADDR_IRQ, 32'h1);
		apb(1'b0, `LVDC_ADDR_IRQ, 32'h0);
		check("flag cleared", rd, 32'h0);
		apb(1'b1, `LVDC_ADDR_IRQ, 32'h6);
		ana_in.comp_below <= 1'b1;
		cyc(6);
		check("irq raised", irq_req, 32'h1);
		ana_in.comp_below <= 1'b0;
		cyc(6);
		check("irq sticky", irq_req, 32'h1);
		tend("detect");
		// wake from sleep, with and without the global enable
		apb(1'b1, `LVDC_ADDR_IRQ, 32'h7);
		cyc(2);
		check("irq low", irq_req, 32'h0);
		nap();
		check("wake gie", wk, 32'h1);
		check("vector gie", wv, 32'h1);
		cyc(4);
		apb(1'b1, `LVDC_ADDR_IRQ, 32'h3);
		nap();
		check("wake no gie", wk, 32'h1);
		check("vector no gie", wv, 32'h0);
		tend("sleep");
		// disable, re-enable restarts the interval, shared reference skips it
		apb(1'b1, `LVDC_ADDR_CTRL, 32'h05);
		cyc(2);
		check("det power off", ana_ctrl.det_power, 32'h0);
		check("ref power off", ana_ctrl.ref_power, 32'h0);
		apb(1'b1, `LVDC_ADDR_CTRL, 32'h15);
		apb(1'b0, `LVDC_ADDR_CTRL, 32'h0);
		check("restart", rd[5], 32'h0);
		apb(1'b1, `LVDC_ADDR_CTRL, 32'h05);
		ana_in.ref_shared <= 1'b1;
		cyc(4);
		apb(1'b1, `LVDC_ADDR_CTRL, 32'h15);
		apb(1'b0, `LVDC_ADDR_CTRL, 32'h0);
		check("shared ref", rd[5], 32'h1);
		tend("restart");
		// reset in mid-run switches the detector off
		ana_in.ref_shared <= 1'b0;
		presetn <= 1'b0;
		cyc(2);
		check("power in reset", ana_ctrl.det_power, 32'h0);
		presetn <= 1'b1;
		apb(1'b0, `LVDC_ADDR_CTRL, 32'h0);
		check("ctrl after reset", rd, 32'h05);
		apb(1'b0, `LVDC_ADDR_IRQ, 32'h0);
		check("irq after reset", rd, 32'h0);
		tend("midreset");
		test_done();
	end
endmodule
